// file: include/cx_regs.svh
// Constants for the core extension register block: offsets, fields, resets, rates.
// Assumes an 8-bit internal register bus with 8-bit offsets.
`ifndef CX_REGS_SVH
`define CX_REGS_SVH

`define CX_OFS_FIRST_PTR_LOW 8'h82
`define CX_OFS_FIRST_PTR_HIGH 8'h83
`define CX_OFS_SECOND_PTR_LOW 8'h84
`define CX_OFS_SECOND_PTR_HIGH 8'h85
`define CX_OFS_PTR_SELECT 8'h86
`define CX_OFS_CLOCK_CONTROL 8'h8E
`define CX_OFS_MOVE_PAGE 8'h92
`define CX_OFS_TIMER_CONTROL 8'hC8
`define CX_OFS_RELOAD_LOW 8'hCA
`define CX_OFS_RELOAD_HIGH 8'hCB
`define CX_OFS_COUNT_LOW 8'hCC
`define CX_OFS_COUNT_HIGH 8'hCD

`define CX_RST_PTR_SELECT 8'h00
`define CX_RST_CLOCK_CONTROL 8'h01
`define CX_RST_MOVE_PAGE 8'h00
`define CX_RST_TIMER_CONTROL 8'h00
`define CX_RST_RELOAD 8'h00

`define CX_BIT_PTR_SEL 0
`define CX_BIT_FIRST_RATE 3
`define CX_BIT_THIRD_RATE 5
`define CX_MASK_CLOCK_CONTROL 8'h3F
`define CX_BIT_OVF_FLAG 7
`define CX_BIT_RX_SOURCE 5
`define CX_BIT_TX_SOURCE 4
`define CX_BIT_RUN 2

`define CX_INSTR_CLKS 4
`define CX_SLOW_CLKS 12
`define CX_BAUD_CLKS 2

`endif

// file: include/cx_pkg.sv
// Types shared by the core extension register block.
// Assumes cx_regs.svh supplies the numeric constants.
package cx_pkg;
   typedef logic [7:0] cx_byte_t;
   typedef enum logic [1:0] {
      CX_SER_SHIFT = 2'h0,
      CX_SER_VAR8 = 2'h1,
      CX_SER_FIX9 = 2'h2,
      CX_SER_VAR9 = 2'h3
   } cx_serial_mode_e;
endpackage : cx_pkg

// file: hdl/cx_rate_ticks.sv
// Timer step generator: one phase counter feeding three timers.
// Assumes event inputs are already synchronised single-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
`include "cx_regs.svh"
module cx_rate_ticks #(
   parameter int NUM_TIMERS = 3
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [NUM_TIMERS-1:0] fastRate,
   input wire logic [NUM_TIMERS-1:0] counterMode,
   input wire logic [NUM_TIMERS-1:0] eventPulse,
   output logic [NUM_TIMERS-1:0] step,
   output logic halfStep
);
   localparam logic [3:0] LastPhase = 4'(`CX_SLOW_CLKS - 1);
   localparam logic [1:0] LastFast = 2'(`CX_INSTR_CLKS - 1);
   logic [3:0] phase;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase <= 4'h0;
      end else if (phase == LastPhase) begin
         phase <= 4'h0;
      end else begin
         phase <= phase + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         halfStep <= 1'b0;
      end else begin
         halfStep <= phase[0];
      end
   end

   for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            step[i] <= 1'b0;
         end else if (counterMode[i]) begin
            step[i] <= eventPulse[i];
         end else if (fastRate[i]) begin
            step[i] <= (phase[1:0] == LastFast);
         end else begin
            step[i] <= (phase == LastPhase);
         end
      end

      a_slow_step: assert property (@(posedge clk) disable iff (!resetn)
         !counterMode[i] && !fastRate[i] |=> step[i] == ($past(phase) == LastPhase))
         else $error("slow step off the twelve-clock phase");
      a_fast_step: assert property (@(posedge clk) disable iff (!resetn)
         !counterMode[i] && fastRate[i] |=> step[i] == ($past(phase[1:0]) == LastFast))
         else $error("fast step off the four-clock phase");
      a_event_step: assert property (@(posedge clk) disable iff (!resetn)
         counterMode[i] |=> step[i] == $past(eventPulse[i]))
         else $error("counter mode step not following event");
   end
endmodule : cx_rate_ticks
`default_nettype wire

// file: hdl/cx_third_timer.sv
// Sixteen-bit auto-reload timer with overflow pulse.
// Assumes step is a single-cycle pulse and writes come from the register bus.
`timescale 1ns/1ns
`default_nettype none
module cx_third_timer #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic step,
   input wire logic run,
   input wire logic [WIDTH-1:0] reloadValue,
   input wire logic writeLow,
   input wire logic writeHigh,
   input wire logic [7:0] writeData,
   output logic [WIDTH-1:0] count,
   output logic overflowPulse
);
   logic wrap;
   assign wrap = run && step && (count == '1);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (writeLow || writeHigh) begin
         if (writeLow) begin
            count[7:0] <= writeData;
         end
         if (writeHigh) begin
            count[WIDTH-1:8] <= writeData[WIDTH-9:0];
         end
      end else if (wrap) begin
         count <= reloadValue;
      end else if (run && step) begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         overflowPulse <= 1'b0;
      end else begin
         overflowPulse <= wrap && !(writeLow || writeHigh);
      end
   end
endmodule : cx_third_timer
`default_nettype wire

// file: hdl/cx_ext_sfr.sv
// Core extension registers: dual data pointers, timer rates, move page,
// third timer control and reload, serial clock source selection.
// Assumes the instruction engine drives the register bus on clk; event pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "cx_regs.svh"
module cx_ext_sfr (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire cx_pkg::cx_byte_t sfrWriteData,
   output cx_pkg::cx_byte_t sfrReadData,
   output logic sfrReadValid,
   output logic sfrHit,
   input wire logic dataPointerIncrement,
   input wire logic moveRequest,
   input wire logic moveIndirect,
   input wire cx_pkg::cx_byte_t moveIndexValue,
   output logic [15:0] moveAddress,
   output logic moveAddressValid,
   output logic [15:0] activeDataPointer,
   output logic [2:0] moveStretch,
   input wire logic [2:0] timerEventPin,
   input wire logic [2:0] timerCounterMode,
   output logic firstTimerStep,
   output logic secondTimerStep,
   input wire logic secondTimerOverflow,
   input wire cx_pkg::cx_serial_mode_e serialMode,
   output logic serialRxClockTick,
   output logic serialTxClockTick,
   input wire logic thirdTimerIrqEnable,
   output logic thirdTimerIrq,
   output logic overflowPulseOut
);
   //----------------------------------------------------------------
   // register storage
   //----------------------------------------------------------------
   cx_pkg::cx_byte_t firstPointerLow;
   cx_pkg::cx_byte_t firstPointerHigh;
   cx_pkg::cx_byte_t secondPointerLow;
   cx_pkg::cx_byte_t secondPointerHigh;
   logic dataPointerSelect;
   logic [5:0] timerClockControl;
   cx_pkg::cx_byte_t externalMovePage;
   cx_pkg::cx_byte_t thirdTimerControl;
   cx_pkg::cx_byte_t reloadLowByte;
   cx_pkg::cx_byte_t reloadHighByte;
   logic [15:0] thirdCount;
   logic thirdOverflow;
   logic [2:0] timerStep;
   logic halfStep;

   logic overflowFlag;
   logic rxClockSource;
   logic txClockSource;
   logic thirdTimerRun;
   logic baudMode;
   logic thirdStep;

   assign overflowFlag = thirdTimerControl[`CX_BIT_OVF_FLAG];
   assign rxClockSource = thirdTimerControl[`CX_BIT_RX_SOURCE];
   assign txClockSource = thirdTimerControl[`CX_BIT_TX_SOURCE];
   assign thirdTimerRun = thirdTimerControl[`CX_BIT_RUN];
   assign baudMode = rxClockSource || txClockSource;
   assign moveStretch = timerClockControl[2:0];

   //----------------------------------------------------------------
   // address decode
   //----------------------------------------------------------------
   function automatic logic isWrite(input logic [7:0] ofs);
      isWrite = sfrWrite && (sfrAddr == ofs);
   endfunction : isWrite

   logic mapped;
   always_comb begin
      case (sfrAddr)
         `CX_OFS_FIRST_PTR_LOW, `CX_OFS_FIRST_PTR_HIGH,
         `CX_OFS_SECOND_PTR_LOW, `CX_OFS_SECOND_PTR_HIGH,
         `CX_OFS_PTR_SELECT, `CX_OFS_CLOCK_CONTROL, `CX_OFS_MOVE_PAGE,
         `CX_OFS_TIMER_CONTROL, `CX_OFS_RELOAD_LOW, `CX_OFS_RELOAD_HIGH,
         `CX_OFS_COUNT_LOW, `CX_OFS_COUNT_HIGH: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   //----------------------------------------------------------------
   // data pointers
   //----------------------------------------------------------------
   logic [15:0] next_pointer;
   assign activeDataPointer = dataPointerSelect ? {secondPointerHigh, secondPointerLow}
                                                : {firstPointerHigh, firstPointerLow};
   assign next_pointer = activeDataPointer + 16'h0001;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dataPointerSelect <= 1'b0;
      end else if (isWrite(`CX_OFS_PTR_SELECT)) begin
         dataPointerSelect <= sfrWriteData[`CX_BIT_PTR_SEL];
      end
   end

   // a bus write to a pointer byte wins over an increment in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         firstPointerLow <= 8'h00;
         firstPointerHigh <= 8'h00;
      end else begin
         if (dataPointerIncrement && !dataPointerSelect) begin
            firstPointerLow <= next_pointer[7:0];
            firstPointerHigh <= next_pointer[15:8];
         end
         if (isWrite(`CX_OFS_FIRST_PTR_LOW)) begin
            firstPointerLow <= sfrWriteData;
         end
         if (isWrite(`CX_OFS_FIRST_PTR_HIGH)) begin
            firstPointerHigh <= sfrWriteData;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         secondPointerLow <= 8'h00;
         secondPointerHigh <= 8'h00;
      end else begin
         if (dataPointerIncrement && dataPointerSelect) begin
            secondPointerLow <= next_pointer[7:0];
            secondPointerHigh <= next_pointer[15:8];
         end
         if (isWrite(`CX_OFS_SECOND_PTR_LOW)) begin
            secondPointerLow <= sfrWriteData;
         end
         if (isWrite(`CX_OFS_SECOND_PTR_HIGH)) begin
            secondPointerHigh <= sfrWriteData;
         end
      end
   end

   //----------------------------------------------------------------
   // clock control and move page
   //----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timerClockControl <= 6'(`CX_RST_CLOCK_CONTROL);
      end else if (isWrite(`CX_OFS_CLOCK_CONTROL)) begin
         timerClockControl <= sfrWriteData[5:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         externalMovePage <= `CX_RST_MOVE_PAGE;
      end else if (isWrite(`CX_OFS_MOVE_PAGE)) begin
         externalMovePage <= sfrWriteData;
      end
   end

   // indirect moves take the page byte as the upper address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         moveAddress <= 16'h0000;
         moveAddressValid <= 1'b0;
      end else begin
         moveAddressValid <= moveRequest;
         if (moveRequest) begin
            moveAddress <= moveIndirect ? {externalMovePage, moveIndexValue}
                                        : activeDataPointer;
         end
      end
   end

   //----------------------------------------------------------------
   // third timer control and reload
   //----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         thirdTimerControl <= `CX_RST_TIMER_CONTROL;
      end else begin
         if (isWrite(`CX_OFS_TIMER_CONTROL)) begin
            thirdTimerControl <= sfrWriteData;
         end
         // hardware set wins over a software clear in the same cycle
         if (thirdOverflow && !baudMode) begin
            thirdTimerControl[`CX_BIT_OVF_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reloadLowByte <= `CX_RST_RELOAD;
         reloadHighByte <= `CX_RST_RELOAD;
      end else begin
         if (isWrite(`CX_OFS_RELOAD_LOW)) begin
            reloadLowByte <= sfrWriteData;
         end
         if (isWrite(`CX_OFS_RELOAD_HIGH)) begin
            reloadHighByte <= sfrWriteData;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         thirdTimerIrq <= 1'b0;
      end else begin
         thirdTimerIrq <= overflowFlag && thirdTimerIrqEnable;
      end
   end

   //----------------------------------------------------------------
   // event pin synchronisers and falling-edge detect
   //----------------------------------------------------------------
   logic [2:0] pinMeta;
   logic [2:0] pinSync;
   logic [2:0] pinLast;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinMeta <= 3'h7;
         pinSync <= 3'h7;
         pinLast <= 3'h7;
      end else begin
         pinMeta <= timerEventPin;
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end

   //----------------------------------------------------------------
   // timer steps and third timer
   //----------------------------------------------------------------
   cx_rate_ticks #(
      .NUM_TIMERS(3)
   ) u_rate_ticks (
      .clk(clk),
      .resetn(resetn),
      .fastRate(timerClockControl[`CX_BIT_THIRD_RATE:`CX_BIT_FIRST_RATE]),
      .counterMode(timerCounterMode),
      .eventPulse(pinLast & ~pinSync),
      .step(timerStep),
      .halfStep(halfStep)
   );

   assign firstTimerStep = timerStep[0];
   assign secondTimerStep = timerStep[1];
   assign thirdStep = baudMode ? halfStep : timerStep[2];

   cx_third_timer #(
      .WIDTH(16)
   ) u_third_timer (
      .clk(clk),
      .resetn(resetn),
      .step(thirdStep),
      .run(thirdTimerRun),
      .reloadValue({reloadHighByte, reloadLowByte}),
      .writeLow(isWrite(`CX_OFS_COUNT_LOW)),
      .writeHigh(isWrite(`CX_OFS_COUNT_HIGH)),
      .writeData(sfrWriteData),
      .count(thirdCount),
      .overflowPulse(thirdOverflow)
   );

   assign overflowPulseOut = thirdOverflow;

   //----------------------------------------------------------------
   // serial port clock source
   //----------------------------------------------------------------
   logic serialVariable;
   assign serialVariable = (serialMode == cx_pkg::CX_SER_VAR8) ||
                           (serialMode == cx_pkg::CX_SER_VAR9);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         serialRxClockTick <= 1'b0;
         serialTxClockTick <= 1'b0;
      end else begin
         serialRxClockTick <= serialVariable &&
            (rxClockSource ? thirdOverflow : secondTimerOverflow);
         serialTxClockTick <= serialVariable &&
            (txClockSource ? thirdOverflow : secondTimerOverflow);
      end
   end

   //----------------------------------------------------------------
   // read path
   //----------------------------------------------------------------
   cx_pkg::cx_byte_t next_readData;
   always_comb begin
      case (sfrAddr)
         `CX_OFS_FIRST_PTR_LOW: next_readData = firstPointerLow;
         `CX_OFS_FIRST_PTR_HIGH: next_readData = firstPointerHigh;
         `CX_OFS_SECOND_PTR_LOW: next_readData = secondPointerLow;
         `CX_OFS_SECOND_PTR_HIGH: next_readData = secondPointerHigh;
         `CX_OFS_PTR_SELECT: next_readData = {7'h00, dataPointerSelect};
         `CX_OFS_CLOCK_CONTROL: next_readData = {2'h0, timerClockControl};
         `CX_OFS_MOVE_PAGE: next_readData = externalMovePage;
         `CX_OFS_TIMER_CONTROL: next_readData = thirdTimerControl;
         `CX_OFS_RELOAD_LOW: next_readData = reloadLowByte;
         `CX_OFS_RELOAD_HIGH: next_readData = reloadHighByte;
         `CX_OFS_COUNT_LOW: next_readData = thirdCount[7:0];
         `CX_OFS_COUNT_HIGH: next_readData = thirdCount[15:8];
         default: next_readData = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sfrReadData <= 8'h00;
         sfrReadValid <= 1'b0;
         sfrHit <= 1'b0;
      end else begin
         sfrReadValid <= sfrRead;
         sfrHit <= (sfrRead || sfrWrite) && mapped;
         if (sfrRead) begin
            sfrReadData <= next_readData;
         end
      end
   end

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic timerControlWrite;
   logic countWrite;
   assign timerControlWrite = isWrite(`CX_OFS_TIMER_CONTROL);
   assign countWrite = isWrite(`CX_OFS_COUNT_LOW) || isWrite(`CX_OFS_COUNT_HIGH);

   a_pointer_pick: assert property (moveRequest && !moveIndirect
      |=> moveAddressValid && moveAddress == (
      $past(dataPointerSelect) ? {$past(secondPointerHigh), $past(secondPointerLow)}
                               : {$past(firstPointerHigh), $past(firstPointerLow)}))
      else $error("direct move address not from selected pointer");
   a_page_address: assert property (moveRequest && moveIndirect
      |=> moveAddress == {$past(externalMovePage), $past(moveIndexValue)})
      else $error("indirect move upper byte not the page register");
   a_stretch_reset: assert property ($rose(resetn) |-> moveStretch == 3'h1)
      else $error("stretch field not one after reset");
   a_flag_set: assert property (thirdOverflow && !baudMode |=> overflowFlag)
      else $error("overflow did not set the flag");
   a_flag_baud: assert property (thirdOverflow && baudMode && !overflowFlag
      && !timerControlWrite |=> !overflowFlag)
      else $error("flag set during baud generation");
   a_flag_sticky: assert property (overflowFlag && !timerControlWrite |=> overflowFlag)
      else $error("flag cleared without a software write");
   a_soft_irq: assert property (timerControlWrite && sfrWriteData[`CX_BIT_OVF_FLAG]
      && thirdTimerIrqEnable ##1 thirdTimerIrqEnable |=> thirdTimerIrq)
      else $error("software flag set raised no request");
   a_timer_stop: assert property (!thirdTimerRun && !countWrite |=> $stable(thirdCount))
      else $error("third timer moved while stopped");
   a_reload_load: assert property (thirdOverflow |->
      thirdCount == {$past(reloadHighByte), $past(reloadLowByte)})
      else $error("overflow did not load the reload value");
   a_pulse_width: assert property (thirdOverflow |=> !thirdOverflow)
      else $error("overflow pulse longer than one clock");
   a_baud_step: assert property (baudMode && thirdTimerRun && !countWrite
      && thirdCount != 16'hFFFF ##1 baudMode && thirdTimerRun && !countWrite
      |=> thirdCount != $past(thirdCount, 2))
      else $error("baud mode counter not advancing every two clocks");
   a_rx_source: assert property (serialVariable && rxClockSource && thirdOverflow
      |=> serialRxClockTick)
      else $error("receive clock not from third timer");
   a_tx_source: assert property (serialVariable && !txClockSource
      |=> serialTxClockTick == $past(secondTimerOverflow))
      else $error("transmit clock not from second timer");
   a_select_read: assert property (sfrRead && sfrAddr == `CX_OFS_PTR_SELECT
      |=> sfrReadData[7:1] == 7'h00)
      else $error("reserved select bits read nonzero");

   c_auto_reload: cover property (thirdOverflow && !baudMode);
   c_baud_reload: cover property (thirdOverflow && baudMode && serialVariable);
   c_set_clear: cover property (thirdOverflow && timerControlWrite);
   c_page_move: cover property (moveRequest && moveIndirect);
endmodule : cx_ext_sfr
`default_nettype wire

// file: verification/cx_peer_timer.sv
// Far-side stand-in: second timer overflow pulses feeding the serial port.
// Assumes the core clock; each pulse lasts one clock.
`timescale 1ns/1ns
`default_nettype none
module cx_peer_timer #(
   parameter int PERIOD = 10
) (
   input wire logic clk,
   input wire logic resetn,
   output logic overflow
);
   int cnt;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 0;
         overflow <= 1'b0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         overflow <= (cnt == PERIOD - 1);
      end
   end
endmodule : cx_peer_timer
`default_nettype wire

// file: verification/cx_ext_sfr_tb.sv
// Bench for the core extension registers: bus access, pointers, page, timer.
// Assumes cx_regs.svh on the include path and the far-side timer model.
`timescale 1ns/1ns
`default_nettype none
`include "cx_regs.svh"
module cx_ext_sfr_tb;
   logic clk, resetn, sfrWrite, sfrRead, sfrReadValid, sfrHit, dataPointerIncrement;
   logic moveRequest, moveIndirect, moveAddressValid, secondTimerOverflow, serialRxClockTick;
   logic serialTxClockTick, thirdTimerIrqEnable, thirdTimerIrq, overflowPulseOut;
   logic [7:0] sfrAddr;
   cx_pkg::cx_byte_t sfrWriteData, sfrReadData, moveIndexValue;
   logic [15:0] moveAddress, activeDataPointer;
   logic [2:0] moveStretch;
   cx_pkg::cx_serial_mode_e serialMode;
   logic [2:0] eventPin, counterMode;
   logic firstTimerStep, secondTimerStep;
   int errCount = 0, nTests = 0, gap;
   int rxTicks = 0, txTicks = 0, firstSteps = 0, secondSteps = 0;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   cx_peer_timer peer (.clk, .resetn, .overflow(secondTimerOverflow));
   cx_ext_sfr uut (.clk, .resetn, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData, .sfrReadData,
      .sfrReadValid, .sfrHit, .dataPointerIncrement, .moveRequest, .moveIndirect,
      .moveIndexValue, .moveAddress, .moveAddressValid, .activeDataPointer, .moveStretch,
      .timerEventPin(eventPin), .timerCounterMode(counterMode), .firstTimerStep, .secondTimerStep,
      .secondTimerOverflow, .serialMode, .serialRxClockTick, .serialTxClockTick,
      .thirdTimerIrqEnable, .thirdTimerIrq, .overflowPulseOut);
   task automatic summarize();
      $display("mismatches %0d, comparisons %0d", errCount, nTests);
      if (errCount == 0 && nTests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         errCount++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // write (w=1) or read; hit and read data land one cycle after the strobe
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic h);
      @(posedge clk);
      #1;
      {sfrAddr, sfrWriteData, sfrWrite, sfrRead} = {a, d, w, !w};
      @(posedge clk);
      #1;
      {sfrWrite, sfrRead} = 2'h0;
      chk({6'h00, sfrHit, sfrReadValid, (w ? d : sfrReadData)}, {6'h00, h, !w, d});
   endtask : acc
   // k overflow pulses; the last gap is a full period
   task automatic waitOvf(input int k, input logic [15:0] exp);
      repeat (k) begin
         gap = 0;
         do begin
            @(posedge clk);
            #1;
            gap++;
         end while (overflowPulseOut !== 1'b1 && gap < 600);
      end
      chk(gap[15:0], exp);
      if (gap >= 600) begin
         summarize();
      end
   endtask : waitOvf
   initial begin
      {resetn, sfrWrite, sfrRead, dataPointerIncrement, moveRequest, moveIndirect} = 6'h00;
      {sfrAddr, sfrWriteData, moveIndexValue, thirdTimerIrqEnable} = 25'h0000000;
      serialMode = cx_pkg::CX_SER_VAR8;
      {counterMode, eventPin} = 6'h07;
      repeat (12) @(posedge clk);
      #1;
      resetn = 1'b1;
      chk({13'h0000, moveStretch}, 16'h0001);
      acc(1'b0, `CX_OFS_PTR_SELECT, 8'h00, 1'b1);
      acc(1'b0, `CX_OFS_CLOCK_CONTROL, 8'h01, 1'b1);
      acc(1'b0, `CX_OFS_MOVE_PAGE, 8'h00, 1'b1);
      acc(1'b0, `CX_OFS_TIMER_CONTROL, 8'h00, 1'b1);
      acc(1'b0, `CX_OFS_RELOAD_LOW, 8'h00, 1'b1);
      acc(1'b0, 8'h87, 8'h00, 1'b0);
      acc(1'b1, `CX_OFS_PTR_SELECT, 8'hFF, 1'b1);
      acc(1'b0, `CX_OFS_PTR_SELECT, 8'h01, 1'b1);
      acc(1'b1, `CX_OFS_CLOCK_CONTROL, 8'hFE, 1'b1);
      acc(1'b0, `CX_OFS_CLOCK_CONTROL, 8'h3E, 1'b1);
      chk({13'h0000, moveStretch}, 16'h0006);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, `CX_OFS_FIRST_PTR_LOW + i[7:0], 8'(32'h56FF1234 >> (8 * i)), 1'b1);
      end
      chk(activeDataPointer, 16'h56FF);
      @(posedge clk);
      #1;
      dataPointerIncrement = 1'b1;
      @(posedge clk);
      #1;
      dataPointerIncrement = 1'b0;
      chk(activeDataPointer, 16'h5700);
      acc(1'b1, `CX_OFS_PTR_SELECT, 8'h00, 1'b1);
      chk(activeDataPointer, 16'h1234);
      acc(1'b1, `CX_OFS_MOVE_PAGE, 8'hAB, 1'b1);
      {moveRequest, moveIndirect, moveIndexValue} = {2'h3, 8'hCD};
      @(posedge clk);
      #1;
      moveRequest = 1'b0;
      chk(moveAddress, 16'hABCD);
      chk({15'h0000, moveAddressValid}, 16'h0001);
      @(posedge clk);
      #1;
      {moveRequest, moveIndirect} = 2'h2;
      @(posedge clk);
      #1;
      moveRequest = 1'b0;
      chk(moveAddress, 16'h1234);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, `CX_OFS_RELOAD_LOW + i[7:0], {7'h7F, i[0]}, 1'b1);
      end
      acc(1'b1, `CX_OFS_CLOCK_CONTROL, 8'h01, 1'b1);
      acc(1'b1, `CX_OFS_TIMER_CONTROL, 8'h04, 1'b1);
      waitOvf(2, 16'h0018);
      acc(1'b0, `CX_OFS_COUNT_LOW, 8'hFE, 1'b1);
      acc(1'b0, `CX_OFS_TIMER_CONTROL, 8'h84, 1'b1);
      acc(1'b1, `CX_OFS_CLOCK_CONTROL, 8'h21, 1'b1);
      waitOvf(3, 16'h0008);
      acc(1'b1, `CX_OFS_TIMER_CONTROL, 8'h00, 1'b1);
      acc(1'b1, `CX_OFS_COUNT_LOW, 8'h10, 1'b1);
      repeat (40) @(posedge clk);
      acc(1'b0, `CX_OFS_COUNT_LOW, 8'h10, 1'b1);
      thirdTimerIrqEnable = 1'b1;
      acc(1'b1, `CX_OFS_TIMER_CONTROL, 8'h80, 1'b1);
      @(posedge clk);
      #1;
      chk({15'h0000, thirdTimerIrq}, 16'h0001);
      acc(1'b1, `CX_OFS_TIMER_CONTROL, 8'h34, 1'b1);
      waitOvf(3, 16'h0004);
      @(posedge clk);
      #1;
      chk({14'h0000, serialRxClockTick, serialTxClockTick}, 16'h0003);
      acc(1'b0, `CX_OFS_TIMER_CONTROL, 8'h34, 1'b1);
      acc(1'b1, `CX_OFS_CLOCK_CONTROL, 8'h11, 1'b1);
      acc(1'b1, `CX_OFS_TIMER_CONTROL, 8'h14, 1'b1);
      {counterMode, eventPin} = 6'h0E;
      repeat (60) begin
         @(posedge clk);
         #1;
         rxTicks += serialRxClockTick;
         txTicks += serialTxClockTick;
         firstSteps += firstTimerStep;
         secondSteps += secondTimerStep;
      end
      chk(rxTicks[15:0], 16'h0006);
      chk(txTicks[15:0], 16'h000F);
      chk(secondSteps[15:0], 16'h000F);
      chk(firstSteps[15:0], 16'h0001);
      summarize();
   end
endmodule : cx_ext_sfr_tb
`default_nettype wire
